// ### design/tmr_pkg.sv
// Purpose: shared constants, register map and types of the timer/watchdog block
// Assumes: AHB-Lite word registers, byte address = 4 * register index
// Notes: hclk runs at 250 MHz

package tmr_pkg;

  // register indices; byte address is index * 4
  localparam int ADDR_LSB = 2;
  localparam int INDEX_W = 6;
  localparam logic [5:0] CONTROL_INDEX = 6'h0D;
  localparam logic [5:0] MASK_INDEX = 6'h0E;
  localparam logic [5:0] COUNT_INDEX = 6'h0F;
  localparam logic [5:0] STATUS_INDEX = 6'h10;
  localparam logic [5:0] COMMAND_INDEX = 6'h11;
  localparam logic [5:0] CONFIG_INDEX = 6'h12;

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic CONFIG_EDGE_RESET = 1'b0;

  // field positions
  localparam int TIMER_FLAG_BIT = 0;
  localparam int TIMER_MASK_BIT = 0;
  localparam int CMD_WDT_CLEAR_BIT = 0;
  localparam int CMD_SLEEP_BIT = 1;
  localparam int CFG_FALLING_BIT = 0;
  localparam int CFG_SLEEP_BIT = 1;
  localparam int CTRL_WDT_ENABLE_BIT = 7;

  localparam logic [7:0] COUNT_MAX = 8'hFF;

  // timing: watchdog period with no prescaling, over a full 8-bit count
  localparam int CLK_PERIOD_NS = 4;
  localparam int WDT_TIMEOUT_MS = 18;
  localparam int WDT_TIMEOUT_NS = WDT_TIMEOUT_MS * 1000000;
  localparam int WDT_COUNT_STEPS = 256;
  localparam int RC_TICK_CYCLES_DEFAULT = WDT_TIMEOUT_NS / CLK_PERIOD_NS / WDT_COUNT_STEPS;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef struct packed {
    logic watchdog_enable_bit;
    logic [2:0] watchdog_prescale_select;
    logic timer_source_select;
    logic [2:0] timer_prescale_select;
  } control_t;

  typedef enum logic [1:0] {
    bus_idle = 2'b00,
    bus_write = 2'b01,
    bus_read_wait = 2'b11,
    bus_read_done = 2'b10
  } bus_phase_t;

  typedef enum logic {
    power_run = 1'b0,
    power_sleep = 1'b1
  } power_state_t;

endpackage

// ### design/prescaler.sv
// Purpose: 8-bit prescaler counter with a power-of-two ratio
// Assumes: tick_in is a one-cycle enable on hclk
// Notes: ratio_select n divides by 2**n, so 0 passes every tick

`timescale 1ns/10ps

module prescaler
  import tmr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [2:0] ratio_select,
  output logic tick_out
);

  logic [7:0] count;
  wire [8:0] mask_wide = (9'h001 << ratio_select) - 9'h001;
  wire [7:0] mask = mask_wide[7:0];
  wire terminal = (count & mask) == mask;

  // clear wins over counting, so a cleared chain restarts a full ratio
  assign tick_out = tick_in & terminal & ~clear;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= 8'h00;
    else if (clear)
      count <= 8'h00;
    else if (tick_in)
      count <= count + 8'h01;
  end

endmodule

// ### design/timer_watchdog_prescaler.sv
// Purpose: 8-bit timer/counter and watchdog, each behind an 8-bit prescaler
// Assumes: single AHB-Lite master, word accesses only, hclk at 250 MHz
// Notes: the RC oscillator is modelled as an enable divided down from hclk

`timescale 1ns/10ps

// How it works
// - two 8-bit prescalers, one before the timer, one before the watchdog.
// - control bits 2..0 choose the timer prescale ratio.
// - control bits 6..4 choose the watchdog prescale ratio.
// - any write to the timer count clears the timer prescaler.
// - watchdog clear or sleep command clears watchdog counter and prescaler.
// - timer count is 8-bit read/write; control bit 3 selects its source.
// - internal source with ratio one counts every clock cycle.
// - external source counts the chosen rising or falling pin edge.
// - watchdog runs off its own tick source and keeps counting in sleep.
// - an enabled watchdog that expires requests a device reset, awake or asleep.
// - control bit 7 turns the watchdog on or off while awake.
// - unprescaled watchdog expiry takes about 18 ms.
// - any device reset clears watchdog counter and prescaler.
// - sleep stops the timer; the watchdog is cleared and keeps running.
module timer_watchdog_prescaler
  import tmr_pkg::*;
#(
  parameter int RC_TICK_CYCLES = RC_TICK_CYCLES_DEFAULT
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic counter_pin,
  input wire logic wake_request,
  output logic timer_irq,
  output logic watchdog_reset,
  output logic sleep_mode
);

  // bus data phase bookkeeping
  bus_phase_t phase;
  bus_phase_t next_phase;
  logic [5:0] phase_index;

  // registers
  control_t control;
  logic [7:0] interrupt_mask;
  logic [7:0] timer_count_value;
  logic timer_overflow_irq_flag;
  logic falling_edge_select;
  power_state_t power_state;
  power_state_t next_power_state;

  // pin synchronisers
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic wake_meta;
  logic wake_sync;

  // watchdog side
  logic [31:0] rc_div;
  logic [7:0] wdt_count;
  logic rc_tick;
  logic timer_tick;
  logic wdt_tick;

  // address phase capture; only word transfers are expected
  // hsize is not decoded, so narrower transfers act as word transfers
  wire addr_phase = hsel & htrans[1] & hready;
  wire [5:0] addr_index = haddr[ADDR_LSB + INDEX_W - 1:ADDR_LSB];

  // a taken address phase wins; the wait state holds hready low, so none lands there
  always_comb
  begin
    case (phase)
      bus_idle: next_phase = bus_idle;
      bus_write: next_phase = bus_idle;
      bus_read_wait: next_phase = bus_read_done;
      bus_read_done: next_phase = bus_idle;
      default: next_phase = bus_idle;
    endcase
    if (addr_phase)
      next_phase = hwrite ? bus_write : bus_read_wait;
  end

  // reads take one wait state so a write just before is already visible
  assign hreadyout = (phase != bus_read_wait);
  // no error path: unmapped words read zero and ignore writes
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase <= bus_idle;
      phase_index <= 6'h00;
    end
    else
    begin
      phase <= next_phase;
      if (addr_phase)
        phase_index <= addr_index;
    end
  end

  // write decode
  wire wr_en = (phase == bus_write);
  wire [7:0] wr_byte = hwdata[7:0];
  wire control_write = wr_en & (phase_index == CONTROL_INDEX);
  wire mask_write = wr_en & (phase_index == MASK_INDEX);
  wire count_write = wr_en & (phase_index == COUNT_INDEX);
  wire status_write = wr_en & (phase_index == STATUS_INDEX);
  wire command_write = wr_en & (phase_index == COMMAND_INDEX);
  wire config_write = wr_en & (phase_index == CONFIG_INDEX);

  wire asleep = (power_state == power_sleep);
  wire wdt_clear_cmd = command_write & wr_byte[CMD_WDT_CLEAR_BIT];
  wire sleep_cmd = command_write & wr_byte[CMD_SLEEP_BIT] & ~asleep;
  wire status_clear = status_write & wr_byte[TIMER_FLAG_BIT];

  // read selection
  logic [7:0] status_byte;
  logic [7:0] config_byte;

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[TIMER_FLAG_BIT] = timer_overflow_irq_flag;
  end

  always_comb
  begin
    config_byte = 8'h00;
    config_byte[CFG_FALLING_BIT] = falling_edge_select;
    config_byte[CFG_SLEEP_BIT] = asleep;
  end

  wire [7:0] read_byte =
    (phase_index == CONTROL_INDEX) ? control :
    (phase_index == MASK_INDEX) ? interrupt_mask :
    (phase_index == COUNT_INDEX) ? timer_count_value :
    (phase_index == STATUS_INDEX) ? status_byte :
    (phase_index == CONFIG_INDEX) ? config_byte : 8'h00;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (phase == bus_read_wait)
      hrdata <= {24'h000000, read_byte};
  end

  // control register; the enable bit only moves while awake
  wire [7:0] control_written = {asleep ? control.watchdog_enable_bit :
                                wr_byte[CTRL_WDT_ENABLE_BIT], wr_byte[6:0]};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      control <= control_t'(CONTROL_RESET);
    else if (control_write)
      control <= control_t'(control_written);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      interrupt_mask <= MASK_RESET;
      falling_edge_select <= CONFIG_EDGE_RESET;
    end
    else
    begin
      if (mask_write)
        interrupt_mask <= wr_byte;
      if (config_write)
        falling_edge_select <= wr_byte[CFG_FALLING_BIT];
    end
  end

  // power state: only a wake request or a reset ends sleep
  always_comb
  begin
    case (power_state)
      power_run:
        if (sleep_cmd)
          next_power_state = power_sleep;
        else
          next_power_state = power_run;
      power_sleep:
        if (wake_sync)
          next_power_state = power_run;
        else
          next_power_state = power_sleep;
      default: next_power_state = power_run;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      power_state <= power_run;
    else
    begin
      case (power_state)
        power_run: power_state <= next_power_state;
        power_sleep: power_state <= next_power_state;
        default: power_state <= power_run;
      endcase
    end
  end

  assign sleep_mode = asleep;

  // pins come from outside the clock domain
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= counter_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      wake_meta <= wake_request;
      wake_sync <= wake_meta;
    end
  end

  // edge detect needs each pin level to last over a clock period
  // pin_prev resets low like the idle pin, so reset makes no false edge
  wire pin_rise = pin_sync & ~pin_prev;
  wire pin_fall = ~pin_sync & pin_prev;
  wire pin_edge = falling_edge_select ? pin_fall : pin_rise;

  // timer source: every clock, or the chosen pin edge; halted in sleep
  wire timer_source = control.timer_source_select ? pin_edge : 1'b1;
  wire timer_prescale_in = timer_source & ~asleep;

  prescaler timer_prescaler
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(count_write),
    .tick_in(timer_prescale_in),
    .ratio_select(control.timer_prescale_select),
    .tick_out(timer_tick)
  );

  // a count write outranks a tick, so that cycle shows no wrap
  wire timer_wrap = timer_tick & (timer_count_value == COUNT_MAX) & ~count_write;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_count_value <= COUNT_RESET;
    else if (count_write)
      timer_count_value <= wr_byte;
    else if (timer_tick)
      timer_count_value <= timer_count_value + 8'h01;
  end

  // a wrap in the same cycle as a software clear keeps the flag set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_overflow_irq_flag <= 1'b0;
    else
      timer_overflow_irq_flag <= timer_wrap |
                                 (timer_overflow_irq_flag & ~status_clear);
  end

  wire timer_overflow_irq_enable = interrupt_mask[TIMER_MASK_BIT];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_irq <= 1'b0;
    else
      timer_irq <= timer_overflow_irq_flag & timer_overflow_irq_enable;
  end

  // free-running tick source standing in for the RC oscillator
  // the default divider makes 256 ticks last about 18 ms at 250 MHz
  wire rc_wrap = (rc_div == 32'(RC_TICK_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rc_div <= 32'h00000000;
      rc_tick <= 1'b0;
    end
    else
    begin
      rc_div <= rc_wrap ? 32'h00000000 : rc_div + 32'h00000001;
      rc_tick <= rc_wrap;
    end
  end

  // the watchdog ignores sleep: it is fed by rc_tick only
  wire wdt_enabled = control.watchdog_enable_bit;
  wire wdt_expire = wdt_enabled & wdt_tick & (wdt_count == COUNT_MAX);
  // expiry stays off the prescaler clear: tick_out already depends on that clear
  // a terminal tick rolls the selected prescaler bits to zero, as a clear would
  wire wdt_restart = wdt_clear_cmd | sleep_cmd;
  wire wdt_clear = wdt_restart | wdt_expire;

  prescaler watchdog_prescaler
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(wdt_restart),
    .tick_in(rc_tick & wdt_enabled),
    .ratio_select(control.watchdog_prescale_select),
    .tick_out(wdt_tick)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wdt_count <= 8'h00;
    else if (wdt_clear)
      wdt_count <= 8'h00;
    else if (wdt_tick)
      wdt_count <= wdt_count + 8'h01;
  end

  // the reset request is a single pulse; the system holds the reset itself
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      watchdog_reset <= 1'b0;
    else
      watchdog_reset <= wdt_expire;
  end

endmodule

// ### verification/counter_source.sv
// Purpose: far-side source that toggles the counter pin
// Assumes: timing counted in hclk cycles
// Notes: each level is held HOLD clocks; the pin keeps its last level
`timescale 1ns/10ps
module counter_source
#(
  parameter int HOLD = 3
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [3:0] toggles,
  output logic counter_pin,
  output logic busy
);
  logic [3:0] left;
  logic [3:0] dwell;
  assign busy = left != 4'h0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      counter_pin <= 1'b0;
      left <= 4'h0;
      dwell <= 4'h0;
    end
    else if (start)
    begin
      left <= toggles;
      dwell <= 4'(HOLD);
    end
    else if (busy && dwell == 4'h1)
    begin
      counter_pin <= ~counter_pin;
      left <= left - 4'h1;
      dwell <= 4'(HOLD);
    end
    else if (busy)
      dwell <= dwell - 4'h1;
  end
endmodule

// ### verification/timer_watchdog_prescaler_assertions.sv
// Purpose: bus, watchdog and sleep checks on the top ports
// Assumes: RC_TICK_CYCLES matches the instance
// Notes: gap saturates, so long quiet runs cannot wrap it
`timescale 1ns/10ps
module timer_watchdog_prescaler_assertions
  import tmr_pkg::*;
#(
  parameter int RC_TICK_CYCLES = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic counter_pin,
  input wire logic wake_request,
  input wire logic timer_irq,
  input wire logic watchdog_reset,
  input wire logic sleep_mode
);
  localparam int WDT_MIN = 255 * RC_TICK_CYCLES;
  logic cmd_ph;
  logic sleep_req;
  logic [15:0] gap;
  wire taken = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_ph <= 1'b0;
      sleep_req <= 1'b0;
      gap <= 16'h0000;
    end
    else
    begin
      cmd_ph <= taken && hwrite && haddr[7:2] == COMMAND_INDEX;
      sleep_req <= cmd_ph && hwdata[CMD_SLEEP_BIT];
      gap <= watchdog_reset ? 16'h0000 : gap + {15'h0000, ~&gap};
    end
  end
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence read_req;
    taken && !hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (read_req |=> one_wait)
    else $error("read wait state wrong");
  a_write_nowait: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  a_rdata_byte: assert property (hreadyout |-> hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_wdt_pulse: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog reset longer than one cycle");
  a_wdt_period: assert property (watchdog_reset |-> gap >= WDT_MIN)
    else $error("watchdog expired too early");
  a_sleep_cause: assert property ($rose(sleep_mode) |-> sleep_req || $past(sleep_req))
    else $error("sleep entered without command");
  a_wake_cause: assert property ($fell(sleep_mode) |-> $past(wake_request, 2))
    else $error("sleep left without wake request");
endmodule
bind timer_watchdog_prescaler timer_watchdog_prescaler_assertions #(
  .RC_TICK_CYCLES(RC_TICK_CYCLES)
) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .counter_pin(counter_pin),
  .wake_request(wake_request), .timer_irq(timer_irq),
  .watchdog_reset(watchdog_reset), .sleep_mode(sleep_mode)
);

// ### verification/timer_watchdog_prescaler_test.sv
// Purpose: self-checking bench for the timer/watchdog block
// Assumes: RC_TICK_CYCLES of 4, so expiry is about 1024 clocks
// Notes: read data is taken as 16 bits so stray upper bits show up
`timescale 1ns/10ps
module timer_watchdog_prescaler_test
  import tmr_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic wake_request = 1'b0;
  logic src_go = 1'b0;
  logic [3:0] src_n = 4'h0;
  logic hreadyout, hresp, counter_pin, timer_irq, watchdog_reset, sleep_mode, src_busy;
  logic [31:0] hrdata;
  logic [15:0] v;
  logic [15:0] w;
  logic [15:0] t;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int pulses = 0;
  int p0;
  logic [21:0] rows [6] = '{
    {CONTROL_INDEX, 8'h7F, 8'h7F}, {COUNT_INDEX, 8'h5A, 8'h5A},
    {MASK_INDEX, 8'h01, 8'h01}, {CONFIG_INDEX, 8'h01, 8'h01},
    {6'h20, 8'h55, 8'h00}, {COMMAND_INDEX, 8'h00, 8'h00}};
  always #2 hclk = ~hclk;
  timer_watchdog_prescaler #(.RC_TICK_CYCLES(4)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .counter_pin(counter_pin),
    .wake_request(wake_request), .timer_irq(timer_irq),
    .watchdog_reset(watchdog_reset), .sleep_mode(sleep_mode));
  counter_source SRC (.hclk(hclk), .hresetn(hresetn), .start(src_go), .toggles(src_n),
    .counter_pin(counter_pin), .busy(src_busy));
  task automatic stop_test;
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    n_checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1)
    begin
      mismatches++;
      $display("wrong value at %0t: got %0h want %0h..%0h", $time, got, lo, hi);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    haddr <= {24'h000000, i, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [5:0] i, output logic [15:0] d);
    haddr <= {24'h000000, i, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata[15:0];
  endtask
  task automatic pins(input logic [3:0] n);
    src_n <= n;
    src_go <= 1'b1;
    @(posedge hclk);
    src_go <= 1'b0;
    do @(posedge hclk); while (src_busy !== 1'b0);
    cyc(6);
  endtask
  // clear after the ratio change so the old ratio adds no count; skipped after a reset
  task automatic wdt_time(input logic [7:0] c, input logic clr, output logic [15:0] n);
    wr(CONTROL_INDEX, c);
    if (clr)
      wr(COMMAND_INDEX, 8'h01);
    n = 16'h0000;
    while (watchdog_reset !== 1'b1)
    begin
      @(posedge hclk);
      n++;
    end
  endtask
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (watchdog_reset === 1'b1)
      pulses <= pulses + 1;
    if (cycles == 30000)
    begin
      mismatches++;
      stop_test();
    end
  end
  initial
  begin
    cyc(16);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({15'h0000, sleep_mode}, 16'h0, 16'h0);
    for (int i = 0; i < 6; i++)
    begin
      wr(rows[i][21:16], rows[i][15:8]);
      rd(rows[i][21:16], v);
      chk(v, {8'h00, rows[i][7:0]}, {8'h00, rows[i][7:0]});
    end
    wr(CONTROL_INDEX, 8'h08);
    wr(CONFIG_INDEX, 8'h00);
    wr(COUNT_INDEX, 8'h00);
    pins(4'h3);
    rd(COUNT_INDEX, v);
    chk(v, 16'h2, 16'h2);
    wr(CONFIG_INDEX, 8'h01);
    wr(COUNT_INDEX, 8'h00);
    pins(4'h3);
    rd(COUNT_INDEX, v);
    chk(v, 16'h2, 16'h2);
    wr(CONTROL_INDEX, 8'h00);
    wr(COUNT_INDEX, 8'h10);
    rd(COUNT_INDEX, v);
    chk(v, 16'h11, 16'h12);
    rd(COUNT_INDEX, w);
    chk(w - v, 16'h3, 16'h3);
    wr(CONTROL_INDEX, 8'h02);
    wr(COUNT_INDEX, 8'h10);
    cyc(40);
    rd(COUNT_INDEX, v);
    chk(v, 16'h19, 16'h1B);
    wr(CONTROL_INDEX, 8'h07);
    cyc(130);
    wr(COUNT_INDEX, 8'h20);
    cyc(100);
    rd(COUNT_INDEX, v);
    chk(v, 16'h20, 16'h20);
    wr(CONTROL_INDEX, 8'h00);
    wr(MASK_INDEX, 8'h00);
    wr(STATUS_INDEX, 8'h01);
    wr(COUNT_INDEX, 8'hFE);
    cyc(8);
    chk({15'h0000, timer_irq}, 16'h0, 16'h0);
    wr(MASK_INDEX, 8'h01);
    cyc(20);
    chk({15'h0000, timer_irq}, 16'h1, 16'h1);
    rd(STATUS_INDEX, v);
    chk(v, 16'h1, 16'h1);
    wr(STATUS_INDEX, 8'h01);
    cyc(2);
    chk({15'h0000, timer_irq}, 16'h0, 16'h0);
    wdt_time(8'h80, 1'b1, t);
    chk(t, 16'd1016, 16'd1040);
    wdt_time(8'h90, 1'b1, t);
    chk(t, 16'd2040, 16'd2064);
    wr(CONTROL_INDEX, 8'h80);
    p0 = pulses;
    repeat (4)
    begin
      cyc(600);
      wr(COMMAND_INDEX, 8'h01);
    end
    chk(16'(pulses - p0), 16'h0, 16'h0);
    wr(CONTROL_INDEX, 8'h00);
    cyc(2500);
    chk(16'(pulses - p0), 16'h0, 16'h0);
    wr(CONTROL_INDEX, 8'h80);
    wr(COMMAND_INDEX, 8'h02);
    p0 = pulses;
    cyc(2);
    chk({15'h0000, sleep_mode}, 16'h1, 16'h1);
    rd(COUNT_INDEX, v);
    wr(CONTROL_INDEX, 8'h00);
    rd(CONTROL_INDEX, w);
    chk(w, 16'h80, 16'h80);
    rd(COUNT_INDEX, w);
    chk(w, v, v);
    cyc(1100);
    chk(16'(pulses - p0), 16'h1, 16'h1);
    wake_request <= 1'b1;
    cyc(6);
    chk({15'h0000, sleep_mode}, 16'h0, 16'h0);
    wake_request <= 1'b0;
    wr(CONTROL_INDEX, 8'h80);
    cyc(600);
    hresetn <= 1'b0;
    cyc(3);
    hresetn <= 1'b1;
    @(posedge hclk);
    wdt_time(8'h80, 1'b0, t);
    chk(t, 16'd1016, 16'd1040);
    stop_test();
  end
endmodule
